/* File: logic/mode_cfg_pkg.sv */
package mode_cfg_pkg;
   // wishbone geometry: register index = byte address / 4
   localparam int unsigned ADR_W = 8;
   localparam int unsigned DAT_W = 32;
   localparam int unsigned SEL_W = 4;
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned IDX_W = 6;
   localparam int unsigned REG_W = 8;
   localparam logic [IDX_W-1:0] IDX_TEST_RESET = 6'h00;
   localparam logic [IDX_W-1:0] IDX_PATH_MODE = 6'h08;
   localparam logic [IDX_W-1:0] IDX_TX_PLL = 6'h09;
   localparam logic [REG_W-1:0] REG_RESET = 8'h00;

   // test_and_soft_reset fields
   localparam int unsigned FORCE_LSB = 4;
   localparam int unsigned FORCE_W = 2;
   // path_mode_config fields
   localparam int unsigned MODE_W = 4;
   localparam int unsigned RX_MODE_LSB = 0;
   localparam int unsigned TX_MODE_LSB = 4;
   // transmit_pll_control fields
   localparam int unsigned TCS_LSB = 0;
   localparam int unsigned PLL_REF_BIT = 2;
   localparam int unsigned PLL_IN_LSB = 3;
   localparam int unsigned PLL_PIN_BIT = 5;
   localparam int unsigned PLL_OUT_LSB = 6;
   localparam int unsigned SEL2_W = 2;

   // bit meaning inside a mode code
   localparam int unsigned MODE_SYNC_BIT = 3;
   localparam int unsigned MODE_E1_BIT = 2;
   localparam int unsigned MODE_J1_BIT = 1;
   localparam int unsigned MODE_ESF_BIT = 0;
   localparam int unsigned MODE_CAS_BIT = 0;
   localparam int unsigned MODE_CRC_BIT = 1;
   localparam int unsigned MODE_RSV_BIT = 2;

   // order follows {output_force_hi_sel, output_force_lo_sel}
   typedef enum logic [1:0] {FORCE_NONE, FORCE_FLOAT, FORCE_LOW, FORCE_HIGH} pin_force_t;
   typedef enum logic [1:0] {TXCLK_PIN, TXCLK_PLL, TXCLK_MCLK, TXCLK_RCLK} tx_clk_src_t;
   typedef enum logic [1:0] {RATE_1544K, RATE_2048K, RATE_64K, RATE_6312K} clk_rate_t;
   typedef enum logic [1:0] {FAM_T1, FAM_J1, FAM_E1, FAM_SYNC} line_family_t;
   typedef enum logic [1:0] {SYNC_2048K, SYNC_64K_8K, SYNC_64K_8K_400, SYNC_6312K} sync_if_t;

   typedef struct packed {
      line_family_t family;
      logic esf;
      logic cas;
      logic crc4;
      sync_if_t sync_kind;
      logic reserved;
   } path_mode_t;

   typedef struct packed {
      logic tx_clock;
      logic pll_ref;
      logic pll_out;
   } clk_pins_t;

   typedef struct packed {
      logic tx_pin;
      logic pll_clk;
      logic mclk;
      logic rclk;
      logic pll_raw;
   } clk_in_t;

   localparam int unsigned PIN_W = $bits(clk_pins_t);
endpackage : mode_cfg_pkg

/* File: logic/path_mode_decoder.sv */
`timescale 1ns/1ns
`default_nettype none
module path_mode_decoder
   import mode_cfg_pkg::*;
#(
   parameter bit TX_PATH = 1'b0
) (
   input wire logic [MODE_W-1:0] i_code,
   output path_mode_t o_mode
);
   wire logic is_sync;
   wire logic is_e1;
   wire logic is_t1j1;
   assign is_sync = i_code[MODE_SYNC_BIT];
   assign is_e1 = !is_sync && i_code[MODE_E1_BIT];
   assign is_t1j1 = !is_sync && !is_e1;
   assign o_mode.family = is_sync ? FAM_SYNC : is_e1 ? FAM_E1 :
                          i_code[MODE_J1_BIT] ? FAM_J1 : FAM_T1;
   assign o_mode.esf = is_t1j1 && i_code[MODE_ESF_BIT];
   // transmit cas comes from serial data, so no cas framing on tx
   assign o_mode.cas = !TX_PATH && is_e1 && i_code[MODE_CAS_BIT];
   assign o_mode.crc4 = is_e1 && i_code[MODE_CRC_BIT];
   assign o_mode.sync_kind = is_sync ? sync_if_t'(i_code[1:0]) : SYNC_2048K;
   assign o_mode.reserved = is_sync ? i_code[MODE_RSV_BIT] :
                            (TX_PATH && is_e1 && i_code[MODE_CAS_BIT]);
endmodule : path_mode_decoder
`default_nettype wire

/* File: logic/pin_force.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_force
   import mode_cfg_pkg::*;
#(
   parameter int unsigned W = PIN_W
) (
   input wire pin_force_t i_force,
   input wire logic [W-1:0] i_val,
   output logic [W-1:0] o_val,
   output logic [W-1:0] o_oe
);
   assign o_oe = (i_force == FORCE_FLOAT) ? '0 : '1;
   assign o_val = (i_force == FORCE_NONE) ? i_val :
                  (i_force == FORCE_HIGH) ? '1 : '0;
endmodule : pin_force
`default_nettype wire

/* File: logic/mode_and_tx_clock_config.sv */
// Operation
// RULE_01: test code 00 drives pins normally; 01 floats all pins and parallel port.
// RULE_02: test code 10 drives pins low, 11 high; parallel port excluded.
// RULE_03: software writes zero to unused test register bits 1-3 and 6-7.
// RULE_04: mode low nibble picks receive mode; codes 0-7 are T1/J1/E1 framings.
// RULE_05: receive codes 8-11 pick sync interfaces; 12-15 reserved, not used.
// RULE_06: mode high nibble picks transmit mode; codes 0-3 are T1/J1 framings.
// RULE_07: with transmit T1 ESF, software keeps frame sync enable cleared.
// RULE_08: transmit code 4 is E1 FAS, 6 is E1 CRC4; 5 and 7 reserved.
// RULE_09: external source embeds cas and multiframe word in timeslot 16.
// RULE_10: transmit codes 8-11 pick sync interfaces; 12-15 reserved, not used.
// RULE_11: 6312kHz transmit also needs pll output rate set to 6312kHz.
// RULE_12: clock select 00 pin, 01 pll, 10 scaled master, 11 recovered.
// RULE_13: pll reference is recovered clock at 0, transmit clock pin at 1.
// RULE_14: pll input rate codes 0-3 mean 1.544M, 2.048M, 64k, 6312k.
// RULE_15: pll pin carries raw pll at 0, transmit clock mux at 1.
// RULE_16: pll output rate field bits 6-7, codes 0-3 as input rates.
// RULE_17: any reset clears every configuration register to zero; here only i_rstn clears them, a write to the reset bit does nothing.
// RULE_18: after reset both paths are T1 D4, transmit clock from pin.
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
module mode_and_tx_clock_config
   import mode_cfg_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [ADR_W-1:0] i_wb_adr,
   input wire logic [SEL_W-1:0] i_wb_sel,
   input wire logic [DAT_W-1:0] i_wb_dat,
   output logic [DAT_W-1:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic i_transmit_clock_pin,
   input wire logic i_pll_clk,
   input wire logic i_scaled_mclk,
   input wire logic i_recovered_clk,
   input wire logic i_pll_raw,
   output clk_pins_t o_pins,
   output logic [PIN_W-1:0] o_pins_oe,
   output logic o_pport_drive_en,
   output path_mode_t o_receive_path_mode,
   output path_mode_t o_transmit_path_mode,
   output clk_rate_t o_pll_input_rate,
   output clk_rate_t o_pll_output_rate
);
   // registers
   pin_force_t force_ff;
   logic [REG_W-1:0] path_mode_config_ff;
   logic [REG_W-1:0] transmit_pll_control_ff;
   logic ack_ff;
   logic [DAT_W-1:0] rdata_ff;
   clk_in_t sync1_ff;
   clk_in_t sync2_ff;
   clk_pins_t pins_ff;
   logic [PIN_W-1:0] pins_oe_ff;
   logic pport_en_ff;
   path_mode_t rx_mode_ff;
   path_mode_t tx_mode_ff;
   clk_rate_t in_rate_ff;
   clk_rate_t out_rate_ff;

   // bus decode
   wire logic req;
   wire logic wr_commit;
   wire logic [IDX_W-1:0] idx;
   wire logic hit_test;
   wire logic hit_mode;
   wire logic hit_pll;
   wire logic lane0_wr;
   assign req = i_wb_cyc && i_wb_stb;
   assign idx = i_wb_adr[IDX_LSB +: IDX_W];
   // low address bits other than the index must be zero to hit
   assign hit_test = (idx == IDX_TEST_RESET) && (i_wb_adr[IDX_LSB-1:0] == '0);
   assign hit_mode = (idx == IDX_PATH_MODE) && (i_wb_adr[IDX_LSB-1:0] == '0);
   assign hit_pll = (idx == IDX_TX_PLL) && (i_wb_adr[IDX_LSB-1:0] == '0);
   // write lands on the edge where the master sees ack
   assign wr_commit = req && ack_ff && i_wb_we;
   assign lane0_wr = wr_commit && i_wb_sel[0];

   wire pin_force_t nxt_force;
   wire logic [REG_W-1:0] nxt_path_mode;
   wire logic [REG_W-1:0] nxt_tx_pll;
   // only the force field is stored; unused bits and the reset bit read zero [RULE_03]
   assign nxt_force = (lane0_wr && hit_test) ?
                      pin_force_t'(i_wb_dat[FORCE_LSB +: FORCE_W]) : force_ff;
   assign nxt_path_mode = (lane0_wr && hit_mode) ? i_wb_dat[REG_W-1:0] :
                          path_mode_config_ff;
   assign nxt_tx_pll = (lane0_wr && hit_pll) ? i_wb_dat[REG_W-1:0] :
                       transmit_pll_control_ff;

   wire logic [REG_W-1:0] test_view;
   wire logic [REG_W-1:0] rd_byte;
   wire logic [DAT_W-1:0] nxt_rdata;
   wire logic nxt_ack;
   assign test_view = REG_W'(force_ff) << FORCE_LSB;
   // unmapped addresses still ack, reading zero and ignoring writes
   assign rd_byte = hit_test ? test_view :
                    hit_mode ? path_mode_config_ff :
                    hit_pll ? transmit_pll_control_ff : REG_RESET;
   assign nxt_rdata = DAT_W'(rd_byte);
   assign nxt_ack = req && !ack_ff;

   // one-cycle ack, registered a cycle after the request, so one wait state
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ack_ff <= 1'b0;
         rdata_ff <= '0;
      end else begin
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         force_ff <= FORCE_NONE; // [RULE_17]
         path_mode_config_ff <= REG_RESET; // [RULE_17] [RULE_18]
         transmit_pll_control_ff <= REG_RESET; // [RULE_17] [RULE_18]
      end else begin
         force_ff <= nxt_force;
         path_mode_config_ff <= nxt_path_mode;
         transmit_pll_control_ff <= nxt_tx_pll;
      end
   end

   // field views
   wire tx_clk_src_t tcs;
   wire logic pll_ref_sel;
   wire logic pll_pin_sel;
   assign tcs = tx_clk_src_t'(transmit_pll_control_ff[TCS_LSB +: SEL2_W]);
   assign pll_ref_sel = transmit_pll_control_ff[PLL_REF_BIT];
   assign pll_pin_sel = transmit_pll_control_ff[PLL_PIN_BIT];

   // mode decode
   path_mode_t rx_mode;
   path_mode_t tx_mode;
   path_mode_decoder #(
      .TX_PATH(1'b0)
   ) u_rx_decode (
      .i_code(path_mode_config_ff[RX_MODE_LSB +: MODE_W]), // [RULE_04] [RULE_05]
      .o_mode(rx_mode)
   );
   path_mode_decoder #(
      .TX_PATH(1'b1)
   ) u_tx_decode (
      .i_code(path_mode_config_ff[TX_MODE_LSB +: MODE_W]), // [RULE_06] [RULE_08] [RULE_10]
      .o_mode(tx_mode)
   );

   // clocks arrive from pins: two flops before any mux reads them
   clk_in_t clk_raw;
   assign clk_raw.tx_pin = i_transmit_clock_pin;
   assign clk_raw.pll_clk = i_pll_clk;
   assign clk_raw.mclk = i_scaled_mclk;
   assign clk_raw.rclk = i_recovered_clk;
   assign clk_raw.pll_raw = i_pll_raw;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= clk_raw;
         sync2_ff <= sync1_ff;
      end
   end

   // clock muxes; sampled at core rate, so inputs must be well below 62.5 MHz
   wire logic tx_clk_mux;
   wire logic pll_ref_mux;
   wire logic pll_pin_mux;
   assign tx_clk_mux = (tcs == TXCLK_PIN) ? sync2_ff.tx_pin : // [RULE_12]
                       (tcs == TXCLK_PLL) ? sync2_ff.pll_clk :
                       (tcs == TXCLK_MCLK) ? sync2_ff.mclk : sync2_ff.rclk;
   assign pll_ref_mux = pll_ref_sel ? sync2_ff.tx_pin : sync2_ff.rclk; // [RULE_13]
   assign pll_pin_mux = pll_pin_sel ? tx_clk_mux : sync2_ff.pll_raw; // [RULE_15]

   clk_pins_t pins_func;
   assign pins_func.tx_clock = tx_clk_mux;
   assign pins_func.pll_ref = pll_ref_mux;
   assign pins_func.pll_out = pll_pin_mux;

   wire logic [PIN_W-1:0] pins_forced;
   wire logic [PIN_W-1:0] pins_oe_forced;
   pin_force #(
      .W(PIN_W)
   ) u_force (
      .i_force(force_ff), // [RULE_01] [RULE_02]
      .i_val(pins_func),
      .o_val(pins_forced),
      .o_oe(pins_oe_forced)
   );
   wire logic nxt_pport_en;
   // parallel port floats only in the float test mode
   assign nxt_pport_en = (force_ff != FORCE_FLOAT); // [RULE_01] [RULE_02]

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pins_ff <= '0;
         pins_oe_ff <= '0;
         pport_en_ff <= 1'b0;
      end else begin
         pins_ff <= clk_pins_t'(pins_forced);
         pins_oe_ff <= pins_oe_forced;
         pport_en_ff <= nxt_pport_en;
      end
   end

   // rate fields feed the pll; a 6312kHz transmit needs both fields set by software
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rx_mode_ff <= '0;
         tx_mode_ff <= '0;
         in_rate_ff <= RATE_1544K;
         out_rate_ff <= RATE_1544K;
      end else begin
         rx_mode_ff <= rx_mode;
         tx_mode_ff <= tx_mode;
         in_rate_ff <= clk_rate_t'(transmit_pll_control_ff[PLL_IN_LSB +: SEL2_W]); // [RULE_14]
         out_rate_ff <= clk_rate_t'(transmit_pll_control_ff[PLL_OUT_LSB +: SEL2_W]); // [RULE_16]
      end
   end

   assign o_wb_ack = ack_ff;
   assign o_wb_dat = rdata_ff;
   assign o_pins = pins_ff;
   assign o_pins_oe = pins_oe_ff;
   assign o_pport_drive_en = pport_en_ff;
   assign o_receive_path_mode = rx_mode_ff;
   assign o_transmit_path_mode = tx_mode_ff;
   assign o_pll_input_rate = in_rate_ff;
   assign o_pll_output_rate = out_rate_ff;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   sequence wr_mode_s;
      req && ack_ff && i_wb_we && i_wb_sel[0] && hit_mode;
   endsequence
   sequence wr_pll_s;
      req && ack_ff && i_wb_we && i_wb_sel[0] && hit_pll;
   endsequence
   sequence wr_test_s;
      req && ack_ff && i_wb_we && i_wb_sel[0] && hit_test;
   endsequence

   bus_ack_pulse_a: assert property (req && !ack_ff |=> ack_ff ##1 !ack_ff)
      else $error("ack not a single cycle pulse");
   rx_mode_decode_a: assert property (wr_mode_s ##0 (i_wb_dat[3:0] == 4'h6) // [RULE_04]
      |=> ##1 rx_mode_ff.family == FAM_E1 && rx_mode_ff.crc4 && !rx_mode_ff.cas)
      else $error("receive code 6 not decoded as e1 crc4");
   rx_sync_if_a: assert property (wr_mode_s ##0 (i_wb_dat[3:2] == 2'h2) // [RULE_05]
      |=> ##1 !rx_mode_ff.reserved && rx_mode_ff.family == FAM_SYNC
      && rx_mode_ff.sync_kind == sync_if_t'($past(i_wb_dat[1:0], 2)))
      else $error("receive sync interface not selected");
   tx_reserved_a: assert property (wr_mode_s ##0 (i_wb_dat[7:4] == 4'h5) // [RULE_08]
      |=> ##1 tx_mode_ff.reserved && !tx_mode_ff.cas)
      else $error("transmit code 5 not reserved");
   tx_sync_kind_a: assert property (wr_mode_s ##0 (i_wb_dat[7:4] == 4'hb) // [RULE_10]
      |=> ##1 tx_mode_ff.sync_kind == SYNC_6312K && !tx_mode_ff.reserved)
      else $error("transmit 6312k interface not selected");
   tx_t1_esf_a: assert property (wr_mode_s ##0 (i_wb_dat[7:4] == 4'h1) // [RULE_06]
      |=> ##1 tx_mode_ff.family == FAM_T1 && tx_mode_ff.esf)
      else $error("transmit t1 esf not decoded");
   float_pins_a: assert property (force_ff == FORCE_FLOAT // [RULE_01]
      |=> pins_oe_ff == '0 && !pport_en_ff)
      else $error("float mode left a driver on");
   force_low_a: assert property (force_ff == FORCE_LOW // [RULE_02]
      |=> pins_oe_ff == '1 && pins_ff == '0 && pport_en_ff)
      else $error("force low not applied");
   force_high_a: assert property (force_ff == FORCE_HIGH // [RULE_02]
      |=> pins_oe_ff == '1 && pins_ff == '1 && pport_en_ff)
      else $error("force high not applied");
   tx_clock_sel_a: assert property (force_ff == FORCE_NONE && tcs == TXCLK_MCLK // [RULE_12]
      |=> pins_ff.tx_clock == $past(sync2_ff.mclk))
      else $error("scaled master clock not selected");
   pll_ref_sel_a: assert property (force_ff == FORCE_NONE // [RULE_13]
      |=> pins_ff.pll_ref == $past(pll_ref_sel ? sync2_ff.tx_pin : sync2_ff.rclk))
      else $error("pll reference mux wrong");
   pll_pin_sel_a: assert property (force_ff == FORCE_NONE && pll_pin_sel // [RULE_15]
      |=> pins_ff.pll_out == pins_ff.tx_clock)
      else $error("pll pin does not follow transmit clock mux");
   pll_rates_a: assert property (wr_pll_s |=> ##1 // [RULE_14] [RULE_16]
      out_rate_ff == clk_rate_t'($past(i_wb_dat[7:6], 2))
      && in_rate_ff == clk_rate_t'($past(i_wb_dat[4:3], 2)))
      else $error("pll rate fields not applied");
   test_reg_write_a: assert property (wr_test_s |=> // [RULE_01] [RULE_02]
      force_ff == pin_force_t'($past(i_wb_dat[5:4])))
      else $error("test mode field not stored");
   normal_pins_a: assert property (i_rstn && force_ff == FORCE_NONE // [RULE_01]
      |=> pins_oe_ff == '1 && pport_en_ff)
      else $error("normal mode left a pin undriven");
   tx_pin_clock_a: assert property (force_ff == FORCE_NONE && tcs == TXCLK_PIN // [RULE_12]
      |=> pins_ff.tx_clock == $past(sync2_ff.tx_pin))
      else $error("transmit clock pin not selected");
   pll_raw_pin_a: assert property (force_ff == FORCE_NONE && !pll_pin_sel // [RULE_15]
      |=> pins_ff.pll_out == $past(sync2_ff.pll_raw))
      else $error("raw pll not routed to pll pin");
   tx_e1_crc_a: assert property (wr_mode_s ##0 (i_wb_dat[7:4] == 4'h6) // [RULE_08]
      |=> ##1 tx_mode_ff.family == FAM_E1 && tx_mode_ff.crc4 && !tx_mode_ff.reserved)
      else $error("transmit code 6 not decoded as e1 crc4");
   rx_j1_esf_a: assert property (wr_mode_s ##0 (i_wb_dat[3:0] == 4'h3) // [RULE_04]
      |=> ##1 rx_mode_ff.family == FAM_J1 && rx_mode_ff.esf)
      else $error("receive j1 esf not decoded");
endmodule : mode_and_tx_clock_config
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import mode_cfg_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [ADR_W-1:0] adr = '0;
   logic [SEL_W-1:0] sel = '0;
   logic [DAT_W-1:0] wdat = '0;
   logic [DAT_W-1:0] rdat;
   logic ack;
   // {tx pin, pll clk, scaled mclk, recovered clk, raw pll}
   logic [4:0] src = '0;
   clk_pins_t pins;
   logic [PIN_W-1:0] pins_oe;
   logic pport_en;
   path_mode_t rx_mode, tx_mode;
   clk_rate_t in_rate, out_rate;
   int num_errors = 0;
   int n_tests = 0;

   always #4 i_core_clk = ~i_core_clk;

   mode_and_tx_clock_config mode_and_tx_clock_config_i (
      .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
      .o_wb_ack(ack), .i_transmit_clock_pin(src[4]), .i_pll_clk(src[3]),
      .i_scaled_mclk(src[2]), .i_recovered_clk(src[1]), .i_pll_raw(src[0]),
      .o_pins(pins), .o_pins_oe(pins_oe), .o_pport_drive_en(pport_en),
      .o_receive_path_mode(rx_mode), .o_transmit_path_mode(tx_mode),
      .o_pll_input_rate(in_rate), .o_pll_output_rate(out_rate));

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // one classic cycle; answer taken at the edge where ack is seen high
   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [3:0] s,
                           input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= {24'h000000, d};
      do begin
         @(posedge i_core_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         $display("unexpected ack timeout at %h", a);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb_cycle

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, a, 4'hf, d, q);
   endtask : wr

   task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] e);
      logic [31:0] q;
      wb_cycle(1'b0, a, 4'hf, 8'h00, q);
      check(name, {24'h000000, e}, q);
   endtask : rd_check

   task automatic settle;
      repeat (8) @(posedge i_core_clk);
   endtask : settle

   task automatic reset_values;
      rd_check("test reg", 8'h00, 8'h00);
      rd_check("mode reg", 8'h20, 8'h00);
      rd_check("pll reg", 8'h24, 8'h00);
      check("rx mode", 32'h0, rx_mode);
      check("tx mode", 32'h0, tx_mode);
      check("rates", 32'h0, {in_rate, out_rate});
      check("oe", 32'h7, pins_oe);
   endtask : reset_values

   task automatic force_modes;
      logic [1:0] c;
      wr(8'h00, 8'h30);
      rd_check("test reg bits", 8'h00, 8'h30);
      for (int i = 0; i < 4; i++) begin
         c = 2'(i + 1);
         wr(8'h00, {2'b00, c, 4'h0});
         settle();
         check("pins oe", (c == 2'd1) ? 32'h0 : 32'h7, pins_oe);
         check("pins", (c == 2'd3) ? 32'h7 : 32'h0, pins);
         check("pport", {31'h0, c != 2'd1}, pport_en);
      end
   endtask : force_modes

   function automatic path_mode_t exp_mode(input logic [3:0] c, input bit tx);
      path_mode_t m;
      m = '0;
      case (c[3:2])
         2'b00: begin
            m.family = c[1] ? FAM_J1 : FAM_T1;
            m.esf = c[0];
         end
         2'b01: begin
            m.family = FAM_E1;
            m.crc4 = c[1];
            m.cas = tx ? 1'b0 : c[0]; // transmit cas rides in serial data
            m.reserved = tx & c[0];
         end
         2'b10: begin
            m.family = FAM_SYNC;
            m.sync_kind = sync_if_t'(c[1:0]);
         end
         default: begin
            m.family = FAM_SYNC;
            m.reserved = 1'b1;
         end
      endcase
      return m;
   endfunction : exp_mode

   task automatic mode_codes;
      logic [3:0] c;
      logic [3:0] t;
      path_mode_t er, et;
      // 6312kHz transmit needs the pll output rate too, so set it first
      wr(8'h24, 8'hc0);
      // no frame sync enable control here, t1 esf transmit needs nothing more
      // codes 12-15 never written: software may not use them
      for (int i = 0; i < 12; i++) begin
         c = 4'(i);
         t = 4'(11 - i);
         er = exp_mode(c, 1'b0);
         et = exp_mode(t, 1'b1);
         wr(8'h20, {t, c});
         settle();
         if (i < 8) check("rx mode", er, rx_mode);
         else check("rx sync", er, rx_mode);
         if (i > 3) check("tx mode", et, tx_mode);
         else check("tx sync", et, tx_mode);
      end
      wr(8'h20, 8'hb0);
      settle();
      check("tx 6312", exp_mode(4'hb, 1'b1), tx_mode);
      // back to t1 d4 before the pll rates change
      wr(8'h20, 8'h00);
   endtask : mode_codes

   task automatic pll_rates;
      for (int i = 0; i < 4; i++) begin
         wr(8'h24, {2'(3 - i), 1'b0, 2'(i), 3'b000});
         settle();
         check("in rate", i, in_rate);
         check("out rate", 3 - i, out_rate);
      end
   endtask : pll_rates

   task automatic clock_mux;
      logic [4:0] v;
      logic tx;
      for (int s = 0; s < 4; s++) begin
         for (int k = 0; k < 2; k++) begin
            v = 5'(1 << (4 - s));
            if (k == 1) v = ~v;
            wr(8'h24, {2'b00, 1'(s >> 1), 2'b00, 1'(s), 2'(s)});
            src <= v;
            settle();
            tx = v[4 - s];
            check("tx clock", tx, pins.tx_clock);
            check("pll ref", s[0] ? v[4] : v[1], pins.pll_ref);
            check("pll out", s[1] ? tx : v[0], pins.pll_out);
         end
      end
      src <= '0;
   endtask : clock_mux

   task automatic odd_accesses;
      logic [31:0] q;
      wr(8'h20, 8'h21);
      wr(8'h28, 8'hff);
      rd_check("unmapped", 8'h28, 8'h00);
      rd_check("misaligned", 8'h21, 8'h00);
      wb_cycle(1'b1, 8'h20, 4'he, 8'h77, q);
      rd_check("sel0 write", 8'h20, 8'h21);
   endtask : odd_accesses

   task automatic second_reset;
      wr(8'h24, 8'hff);
      @(posedge i_core_clk);
      i_rstn <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      reset_values();
   endtask : second_reset

   initial begin
      #160000;
      num_errors++;
      $display("unexpected watchdog expired");
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge i_core_clk);
      i_rstn <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      reset_values();
      force_modes();
      mode_codes();
      pll_rates();
      clock_mux();
      odd_accesses();
      second_reset();
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
